/* File: hw/blcc_cmd.sv */
// loader command handler: node address set/get, session baud, acknowledge
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "blcc_params.svh"

module blcc_cmd #(
    parameter int BUF_BYTES = 4
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // link bytes
    input wire blcc_pkg::blcc_byte_t rx_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    input wire logic tx_idle_i,
    input wire logic link_is_uart_i,
    // protection and nvm state
    input wire blcc_pkg::blcc_guard_t guard_i,
    input wire logic [7:0] cfg_addr_i,
    output logic cfg_wr_o,
    output logic [7:0] cfg_wdata_o,
    // session and interrupt
    output logic [1:0] baud_sel_o,
    output logic irq_o
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (BUF_BYTES < 2 || BUF_BYTES > 255) begin : g_chk
        $error("BUF_BYTES must lie in 2..255");
    end

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    blcc_pkg::blcc_state_t st_r;
    logic [7:0] len_r;
    logic [7:0] cnt_r;
    logic [7:0] buf_r [BUF_BYTES];
    logic [7:0] resp_r [4];
    logic [2:0] tx_left_r;
    logic baud_pend_r;
    logic [1:0] baud_new_r;
    logic [1:0] baud_r;
    logic [15:0] code_r;
    logic [`BLCC_EV_W-1:0] stat_r;
    logic [`BLCC_EV_W-1:0] mask_r;
    logic [31:0] rdata_r;
    logic cfg_wr_r;
    logic [7:0] cfg_wdata_r;

    // execution decision
    logic ex_known;
    logic ex_final;
    logic ex_err;
    logic ex_cfg;
    logic ex_baud;
    logic [15:0] ex_code;
    logic [7:0] ex_type;
    logic [7:0] ex_arg;
    logic tx_take;
    logic tx_last;

    assign ex_type = buf_r[0];
    assign ex_arg = buf_r[1];
    assign tx_take = (st_r == blcc_pkg::BLCC_S_TX) && tx_ready_i;
    assign tx_last = tx_take && (tx_left_r == 3'h1);

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    always_comb begin
        ex_known = 1'b1;
        ex_final = 1'b0;
        ex_cfg = 1'b0;
        ex_baud = 1'b0;
        ex_code = `BLCC_RC_OK;
        unique case (ex_type)
            `BLCC_TYPE_NODE_SET: begin
                if (len_r != `BLCC_LEN_SET) begin
                    ex_code = `BLCC_RC_LEN_BAD;
                end else if (guard_i.rd_prot_any) begin
                    ex_code = `BLCC_RC_RD_PROT;
                end else if (guard_i.wr_prot_code || guard_i.cfg_wr_prot) begin
                    ex_code = `BLCC_RC_CFG_WP;
                end else if (ex_arg == `BLCC_NODE_BAD) begin
                    ex_code = `BLCC_RC_NODE_BAD;
                end else if (guard_i.sem_busy) begin
                    ex_code = `BLCC_RC_SEM;
                end else if (guard_i.asm_buf_err) begin
                    ex_code = `BLCC_RC_BUF_MODE;
                end else begin
                    ex_cfg = 1'b1;
                end
            end
            `BLCC_TYPE_NODE_GET: begin
                if (len_r != `BLCC_LEN_GET) begin
                    ex_code = `BLCC_RC_LEN_BAD;
                end else if (guard_i.rd_prot_any) begin
                    ex_code = `BLCC_RC_RD_PROT;
                end else begin
                    ex_final = 1'b1;
                end
            end
            `BLCC_TYPE_BAUD: begin
                if (len_r != `BLCC_LEN_SET) begin
                    ex_code = `BLCC_RC_LEN_BAD;
                end else if (guard_i.rd_prot_any) begin
                    ex_code = `BLCC_RC_RD_PROT;
                end else if (!link_is_uart_i || ex_arg > `BLCC_BAUD_MAX) begin
                    ex_code = `BLCC_RC_BAUD_FAIL;
                end else begin
                    ex_baud = 1'b1;
                end
            end
            default: begin
                ex_known = 1'b0;
            end
        endcase
        ex_err = (ex_code != `BLCC_RC_OK);
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= blcc_pkg::BLCC_S_LEN;
        end else begin
            unique case (st_r)
                blcc_pkg::BLCC_S_LEN: begin
                    if (rx_i.valid && rx_i.data != 8'h00) begin
                        st_r <= blcc_pkg::BLCC_S_BODY;
                    end
                end
                blcc_pkg::BLCC_S_BODY: begin
                    if (rx_i.valid && cnt_r == 8'h01) begin
                        st_r <= blcc_pkg::BLCC_S_EXEC;
                    end
                end
                blcc_pkg::BLCC_S_EXEC: begin
                    st_r <= ex_known ? blcc_pkg::BLCC_S_TX
                                     : blcc_pkg::BLCC_S_LEN;
                end
                blcc_pkg::BLCC_S_TX: begin
                    if (tx_last) begin
                        st_r <= baud_pend_r ? blcc_pkg::BLCC_S_BAUD
                                            : blcc_pkg::BLCC_S_LEN;
                    end
                end
                blcc_pkg::BLCC_S_BAUD: begin
                    if (tx_idle_i) begin
                        st_r <= blcc_pkg::BLCC_S_LEN;
                    end
                end
                default: begin
                    st_r <= blcc_pkg::BLCC_S_LEN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // receive buffer
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            len_r <= 8'h00;
            cnt_r <= 8'h00;
            for (int i = 0; i < BUF_BYTES; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else if (rx_i.valid && st_r == blcc_pkg::BLCC_S_LEN) begin
            len_r <= rx_i.data;
            cnt_r <= rx_i.data;
        end else if (rx_i.valid && st_r == blcc_pkg::BLCC_S_BODY) begin
            cnt_r <= cnt_r - 8'h01;
            // surplus bytes of long messages are dropped
            for (int i = 0; i < BUF_BYTES; i++) begin
                if (8'(i) == len_r - cnt_r) begin
                    buf_r[i] <= rx_i.data;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // response builder and byte shifter
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                resp_r[i] <= 8'h00;
            end
            tx_left_r <= 3'h0;
            code_r <= `BLCC_RC_OK;
        end else if (st_r == blcc_pkg::BLCC_S_EXEC && ex_known) begin
            code_r <= ex_code;
            if (ex_final) begin
                resp_r[0] <= `BLCC_LEN_FINAL;
                resp_r[1] <= `BLCC_TYPE_FINAL;
                resp_r[2] <= cfg_addr_i;
                resp_r[3] <= 8'h00;
                tx_left_r <= 3'h3;
            end else begin
                resp_r[0] <= `BLCC_LEN_ACK;
                resp_r[1] <= `BLCC_TYPE_ACK;
                resp_r[2] <= ex_code[15:8];
                resp_r[3] <= ex_code[7:0];
                tx_left_r <= 3'h4;
            end
        end else if (tx_take) begin
            resp_r[0] <= resp_r[1];
            resp_r[1] <= resp_r[2];
            resp_r[2] <= resp_r[3];
            resp_r[3] <= 8'h00;
            tx_left_r <= tx_left_r - 3'h1;
        end
    end

    assign tx_valid_o = (st_r == blcc_pkg::BLCC_S_TX);
    assign tx_data_o = resp_r[0];

    // ------------------------------------------------------------------
    // config sector write
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_wr_r <= 1'b0;
            cfg_wdata_r <= 8'h00;
        end else begin
            cfg_wr_r <= (st_r == blcc_pkg::BLCC_S_EXEC) && ex_cfg;
            if ((st_r == blcc_pkg::BLCC_S_EXEC) && ex_cfg) begin
                cfg_wdata_r <= ex_arg;
            end
        end
    end

    assign cfg_wr_o = cfg_wr_r;
    assign cfg_wdata_o = cfg_wdata_r;

    // ------------------------------------------------------------------
    // session baud rate
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            baud_pend_r <= 1'b0;
            baud_new_r <= `BLCC_BAUD_RST;
            baud_r <= `BLCC_BAUD_RST;
        end else if (st_r == blcc_pkg::BLCC_S_EXEC) begin
            // held in a volatile flop only
            baud_pend_r <= ex_baud;
            baud_new_r <= ex_arg[1:0];
        // switch once the line is idle
        end else if (st_r == blcc_pkg::BLCC_S_BAUD && tx_idle_i) begin
            baud_r <= baud_new_r;
            baud_pend_r <= 1'b0;
        end
    end

    assign baud_sel_o = baud_r;

    // ------------------------------------------------------------------
    // event status, mask and interrupt
    // ------------------------------------------------------------------
    logic [`BLCC_EV_W-1:0] ev_set;
    logic [`BLCC_EV_W-1:0] ev_clr;

    always_comb begin
        ev_set = '0;
        ev_set[`BLCC_EV_OK] = (st_r == blcc_pkg::BLCC_S_EXEC) && ex_known
                              && !ex_err;
        ev_set[`BLCC_EV_ERR] = (st_r == blcc_pkg::BLCC_S_EXEC) && ex_known
                               && ex_err;
        ev_set[`BLCC_EV_BAUD] = (st_r == blcc_pkg::BLCC_S_BAUD) && tx_idle_i;
        ev_set[`BLCC_EV_CFG] = cfg_wr_r;
        ev_clr = (wr_i && addr_i == `BLCC_OFS_STATUS)
                 ? wdata_i[`BLCC_EV_W-1:0] : '0;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            stat_r <= '0;
        end else begin
            // a new event outweighs a clear in the same cycle
            stat_r <= (stat_r & ~ev_clr) | ev_set;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mask_r <= `BLCC_MASK_RST;
        end else if (wr_i && addr_i == `BLCC_OFS_MASK) begin
            mask_r <= wdata_i[`BLCC_EV_W-1:0];
        end
    end

    assign irq_o = |(stat_r & mask_r);

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_i) begin
            unique case (addr_i)
                `BLCC_OFS_STATUS: rdata_r <= {28'h000_0000, stat_r};
                `BLCC_OFS_MASK: rdata_r <= {28'h000_0000, mask_r};
                `BLCC_OFS_STATE: rdata_r <= {code_r, 8'h00, 6'h00, baud_r};
                default: rdata_r <= 32'h0000_0000;
            endcase
        end else begin
            rdata_r <= 32'h0000_0000;
        end
    end

    assign rdata_o = rdata_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    logic ex_now;
    assign ex_now = (st_r == blcc_pkg::BLCC_S_EXEC) && ex_known;

    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("response byte changed while stalled");

    property p_cfg_guard;
        cfg_wr_o |-> $past(!guard_i.rd_prot_any && !guard_i.wr_prot_code
                           && ex_type == `BLCC_TYPE_NODE_SET);
    endproperty
    a_cfg_guard: assert property (p_cfg_guard)
        else $error("config write despite protection");

    property p_cfg_data;
        cfg_wr_o |-> cfg_wdata_o == $past(ex_arg)
            && baud_sel_o == $past(baud_r);
    endproperty
    a_cfg_data: assert property (p_cfg_data)
        else $error("config write carries wrong address");

    property p_final;
        ex_now && ex_final |=> resp_r[0] == `BLCC_LEN_FINAL
            && resp_r[1] == `BLCC_TYPE_FINAL && resp_r[2] == $past(cfg_addr_i);
    endproperty
    a_final: assert property (p_final)
        else $error("final block malformed");

    property p_get_prot;
        ex_now && ex_type == `BLCC_TYPE_NODE_GET && len_r == `BLCC_LEN_GET
            && guard_i.rd_prot_any
            |=> resp_r[1] == `BLCC_TYPE_ACK && code_r == `BLCC_RC_RD_PROT;
    endproperty
    a_get_prot: assert property (p_get_prot)
        else $error("address read not refused");

    property p_ack;
        ex_now && !ex_final |=> tx_valid_o && resp_r[0] == `BLCC_LEN_ACK
            && resp_r[1] == `BLCC_TYPE_ACK && tx_left_r == 3'h4;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge block malformed");

    property p_code;
        ex_now && !ex_final |=> ({resp_r[2], resp_r[3]} != 16'h0000)
            == $past(guard_i.rd_prot_any || ex_err);
    endproperty
    a_code: assert property (p_code)
        else $error("result code disagrees with outcome");

    property p_baud_late;
        $changed(baud_sel_o) |-> $past(st_r) == blcc_pkg::BLCC_S_BAUD
            && $past(tx_idle_i) && !tx_valid_o;
    endproperty
    a_baud_late: assert property (p_baud_late)
        else $error("baud changed before response finished");

    property p_baud_ref;
        ex_now && ex_type == `BLCC_TYPE_BAUD
            && (!link_is_uart_i || guard_i.rd_prot_any)
            |=> !baud_pend_r ##1 $stable(baud_sel_o);
    endproperty
    a_baud_ref: assert property (p_baud_ref)
        else $error("baud change accepted while refused");

    property p_baud_vol;
        baud_pend_r |-> !cfg_wr_o;
    endproperty
    a_baud_vol: assert property (p_baud_vol)
        else $error("baud change wrote config sector");

    c_set_ok: cover property (cfg_wr_o);
    c_get: cover property (ex_now && ex_final ##[1:20] tx_last);
    c_baud: cover property ($changed(baud_sel_o));
    c_irq: cover property (irq_o && stat_r[`BLCC_EV_ERR]);

endmodule : blcc_cmd

/* File: hw/blcc_params.svh */
// offsets, field values, result codes and reset values of the loader handler
`ifndef BLCC_PARAMS_SVH
`define BLCC_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define BLCC_OFS_STATUS 8'h00
`define BLCC_OFS_MASK 8'h04
`define BLCC_OFS_STATE 8'h08

// ----------------------------------------------------------------------
// status and mask bit positions
// ----------------------------------------------------------------------
`define BLCC_EV_OK 0
`define BLCC_EV_ERR 1
`define BLCC_EV_BAUD 2
`define BLCC_EV_CFG 3
`define BLCC_EV_W 4
`define BLCC_MASK_RST 4'h0

// ----------------------------------------------------------------------
// message fields
// ----------------------------------------------------------------------
`define BLCC_TYPE_NODE_SET 8'h91
`define BLCC_TYPE_NODE_GET 8'h92
`define BLCC_TYPE_BAUD 8'h93
`define BLCC_TYPE_FINAL 8'h80
`define BLCC_TYPE_ACK 8'h81
`define BLCC_LEN_SET 8'h02
`define BLCC_LEN_GET 8'h01
`define BLCC_LEN_FINAL 8'h02
`define BLCC_LEN_ACK 8'h03
`define BLCC_NODE_BAD 8'h00
`define BLCC_BAUD_MAX 8'h02
`define BLCC_BAUD_RST 2'h0

// ----------------------------------------------------------------------
// signed result codes
// ----------------------------------------------------------------------
`define BLCC_RC_OK 16'h0000
`define BLCC_RC_RD_PROT 16'hfff0
`define BLCC_RC_CFG_WP 16'hffef
`define BLCC_RC_NODE_BAD 16'hffee
`define BLCC_RC_SEM 16'hffed
`define BLCC_RC_BUF_MODE 16'hffec
`define BLCC_RC_BAUD_FAIL 16'hffeb
`define BLCC_RC_LEN_BAD 16'hffea

`endif

/* File: hw/blcc_pkg.sv */
// types shared by the loader command handler
package blcc_pkg;

    typedef enum logic [2:0] {
        BLCC_S_LEN = 3'b000,
        BLCC_S_BODY = 3'b001,
        BLCC_S_EXEC = 3'b010,
        BLCC_S_TX = 3'b011,
        BLCC_S_BAUD = 3'b100
    } blcc_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } blcc_byte_t;

    typedef struct packed {
        logic rd_prot_any;
        logic wr_prot_code;
        logic cfg_wr_prot;
        logic sem_busy;
        logic asm_buf_err;
    } blcc_guard_t;

endpackage : blcc_pkg

/* File: bench/blcc_host_model.sv */
// host-side transmitter model: byte take handshake and line idle flag
`timescale 1ns/1ns

module blcc_host_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // response bytes from the handler
    input wire logic tx_valid_i,
    input wire logic slow_i,
    output logic tx_ready_o,
    output logic tx_idle_o
);
    logic ready_r;
    logic [2:0] drain_r;

    // slow mode stalls the take at random
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            ready_r <= 1'b1;
        else
            ready_r <= slow_i ? 1'($urandom_range(1)) : 1'b1;
    end

    // line busy until last byte sent
    always_ff @(posedge ref_clk_i) begin
        if (rst_i)
            drain_r <= 3'h0;
        else if (tx_valid_i && tx_ready_o)
            drain_r <= 3'h4;
        else if (drain_r != 3'h0)
            drain_r <= drain_r - 3'h1;
    end

    assign tx_ready_o = tx_valid_i && ready_r;
    assign tx_idle_o = (drain_r == 3'h0) && !tx_valid_i;
endmodule : blcc_host_model

/* File: bench/tb_boot_loader_config_commands.sv */
// self-checking bench of the loader command handler
`timescale 1ns/1ns
`include "blcc_params.svh"

`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module tb_boot_loader_config_commands;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    blcc_pkg::blcc_byte_t rx = '0;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic tx_idle;
    logic link_uart = 1'b1;
    blcc_pkg::blcc_guard_t guard = '0;
    logic [7:0] cfg_addr = 8'h10;
    logic cfg_wr;
    logic [7:0] cfg_wdata;
    logic [1:0] baud_sel;
    logic irq;
    logic slow = 1'b0;
    logic [7:0] rxq[$];
    int num_errors = 0;
    int n_tests = 0;
    int n_cfg = 0;
    logic [7:0] last_cfg = 8'h00;

    blcc_cmd blcc_cmd_inst (.ref_clk_i(clk), .rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_ready_i(tx_ready),
        .tx_idle_i(tx_idle), .link_is_uart_i(link_uart), .guard_i(guard),
        .cfg_addr_i(cfg_addr), .cfg_wr_o(cfg_wr), .cfg_wdata_o(cfg_wdata),
        .baud_sel_o(baud_sel), .irq_o(irq));

    blcc_host_model blcc_host_model_inst (.ref_clk_i(clk), .rst_i(rst),
        .tx_valid_i(tx_valid), .slow_i(slow), .tx_ready_o(tx_ready),
        .tx_idle_o(tx_idle));

    initial begin
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // monitors and helpers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (tx_valid && tx_ready)
            rxq.push_back(tx_data);
        if (cfg_wr) begin
            n_cfg++;
            last_cfg = cfg_wdata;
        end
    end

    function automatic logic [31:0] ack(input logic [15:0] c);
        return {`BLCC_LEN_ACK, `BLCC_TYPE_ACK, c};
    endfunction : ack

    function automatic logic [31:0] fin(input logic [7:0] a);
        return {8'h00, `BLCC_LEN_FINAL, `BLCC_TYPE_FINAL, a};
    endfunction : fin

    task automatic close_out;
        if (num_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task automatic send(input logic [7:0] b[$]);
        slow <= 1'($urandom_range(1));
        foreach (b[i]) begin
            rx <= {1'b1, b[i]};
            @(posedge clk);
        end
        rx <= '0;
    endtask : send

    task automatic resp(input int n, output logic [31:0] v);
        int k;
        k = 0;
        while (rxq.size() < n && k < 300) begin
            @(posedge clk);
            k++;
        end
        v = 32'h0;
        // a missing response counts once and reads as zeros
        if (k >= 300)
            num_errors++;
        else
            repeat (n) v = {v[23:0], rxq.pop_front()};
    endtask : resp

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : reg_rd

    initial begin
        #400000;
        num_errors++;
        close_out();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] v;
        logic [7:0] nn;
        logic [4:0] g[6];
        logic [15:0] rc[6];
        logic [1:0] old;
        int k;
        v = $urandom(32'h9f7d);
        g = '{5'h10, 5'h08, 5'h04, 5'h00, 5'h02, 5'h01};
        rc = '{`BLCC_RC_RD_PROT, `BLCC_RC_CFG_WP, `BLCC_RC_CFG_WP,
            `BLCC_RC_NODE_BAD, `BLCC_RC_SEM, `BLCC_RC_BUF_MODE};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(`BLCC_OFS_STATE, v);
        `CHK(v, 32'h0)
        reg_rd(`BLCC_OFS_MASK, v);
        `CHK(v, 32'h0)
        reg_rd(8'h0c, v);
        `CHK(v, 32'h0)
        reg_wr(`BLCC_OFS_MASK, 32'hf);
        cfg_addr <= 8'($urandom_range(1, 254));
        send('{`BLCC_LEN_GET, `BLCC_TYPE_NODE_GET});
        // host waits for the whole response
        resp(3, v);
        `CHK(v, fin(cfg_addr))
        guard <= 5'h10;
        send('{`BLCC_LEN_GET, `BLCC_TYPE_NODE_GET});
        resp(4, v);
        `CHK(v, ack(`BLCC_RC_RD_PROT))
        nn = cfg_addr + 8'h01;
        for (int i = 0; i < 6; i++) begin
            guard <= g[i];
            send('{`BLCC_LEN_SET, `BLCC_TYPE_NODE_SET, i == 3 ? 8'h00 : nn});
            resp(4, v);
            `CHK(v, ack(rc[i]))
            `CHK(n_cfg, 0)
        end
        guard <= 5'h00;
        send('{8'h03, `BLCC_TYPE_NODE_SET, nn, 8'h00});
        resp(4, v);
        `CHK(v, ack(`BLCC_RC_LEN_BAD))
        send('{`BLCC_LEN_SET, `BLCC_TYPE_NODE_SET, nn});
        resp(4, v);
        `CHK(v, ack(`BLCC_RC_OK))
        `CHK(n_cfg, 1)
        `CHK(last_cfg, nn)
        send('{`BLCC_LEN_GET, `BLCC_TYPE_NODE_GET});
        resp(3, v);
        `CHK(v, fin(cfg_addr))
        reg_rd(`BLCC_OFS_STATUS, v);
        `CHK(v, 32'hb)
        `CHK(irq, 1'b1)
        reg_wr(`BLCC_OFS_MASK, 32'h0);
        `CHK(irq, 1'b0)
        reg_wr(`BLCC_OFS_MASK, 32'hf);
        reg_wr(`BLCC_OFS_STATUS, 32'hf);
        reg_rd(`BLCC_OFS_STATUS, v);
        `CHK(v, 32'h0)
        `CHK(irq, 1'b0)
        for (int s = 2; s < 5; s++) begin
            old = baud_sel;
            // selector values 2, 0 and 1
            send('{`BLCC_LEN_SET, `BLCC_TYPE_BAUD, 8'(s % 3)});
            resp(4, v);
            `CHK(v, ack(`BLCC_RC_OK))
            `CHK(baud_sel, old)
            k = 0;
            // host moves on once the new rate applies
            while (baud_sel !== 2'(s % 3) && k < 50) begin
                @(posedge clk);
                k++;
            end
            `CHK(baud_sel, 2'(s % 3))
            `CHK(n_cfg, 1)
        end
        for (int i = 0; i < 3; i++) begin
            link_uart <= (i != 0);
            guard <= (i == 2) ? 5'h10 : 5'h00;
            send('{`BLCC_LEN_SET, `BLCC_TYPE_BAUD, i == 1 ? 8'h03 : 8'h02});
            resp(4, v);
            `CHK(v, ack(i == 2 ? rc[0] : `BLCC_RC_BAUD_FAIL))
            repeat (8) @(posedge clk);
            `CHK(baud_sel, 2'h1)
        end
        reg_rd(`BLCC_OFS_STATE, v);
        `CHK(v, {`BLCC_RC_RD_PROT, 16'h0001})
        reg_rd(`BLCC_OFS_STATUS, v);
        `CHK(v, 32'h7)
        close_out();
    end
endmodule : tb_boot_loader_config_commands
